//--- verification/etw_frontend_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module etw_frontend_tb_top;
  localparam int WAKE = 20;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scl, m_low, sda_o, sda_oe, rx_first, rx_valid, tx_ready;
  logic standby, idle, start_p, stop_p, nack_p, ovr_p, early_p;
  logic rx_ready = 1'b0;
  logic tx_valid = 1'b0;
  logic tx_mode = 1'b0;
  logic ack_en = 1'b1;
  logic rx_en = 1'b0;
  logic first = 1'b0;
  logic [7:0] rx_data;
  logic [7:0] tx_data = 8'h00;
  int fails = 0;
  int checks_done = 0;
  int cyc = 0;
  int seed = 32'h4080;
  int n_start = 0, n_stop = 0, n_nack = 0, n_ovr = 0, n_early = 0, n_oe = 0;
  etw_pkg::etw_rx_s exp_q[$];
  logic [7:0] tx_q[$];
  // open-drain wire with pull-up
  wire sda = !(m_low || (sda_oe && !sda_o));
  etw_frontend #(.FIFO_DEPTH(etw_pkg::RX_FIFO_DEPTH), .WAKE_CYC(WAKE)) dut (
    .CLOCK_I(clk), .RSTN_I(rstn), .SCL_I(scl), .SDA_I(sda), .SDA_O(sda_o),
    .SDA_OE_O(sda_oe), .RX_DATA_O(rx_data), .RX_FIRST_O(rx_first),
    .RX_VALID_O(rx_valid), .RX_READY_I(rx_ready), .TX_DATA_I(tx_data),
    .TX_VALID_I(tx_valid), .TX_READY_O(tx_ready), .TX_MODE_I(tx_mode), .ACK_I(ack_en),
    .STANDBY_O(standby), .BUS_IDLE_O(idle), .START_O(start_p), .STOP_O(stop_p),
    .NACK_O(nack_p), .OVERRUN_O(ovr_p), .EARLY_CMD_O(early_p));
  etw_master_model #(.PH_NS(330), .WAIT_NS(WAKE * 40)) m (
    .scl_o(scl), .sda_low_o(m_low), .sda_i(sda));
  initial forever #20 clk = ~clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    rx_ready <= #1 rx_en & 1'($random(seed));
    if (rstn) begin
      if (start_p === 1'b1) n_start++;
      if (stop_p === 1'b1) n_stop++;
      if (nack_p === 1'b1) n_nack++;
      if (ovr_p === 1'b1) n_ovr++;
      if (early_p === 1'b1) n_early++;
      if (rx_valid === 1'b1 && rx_ready) begin
        if (exp_q.size() == 0) `CHK("rx_extra", 1'b0, 1'b1)
        else begin
          `CHK("rx_data", exp_q[0].data, rx_data)
          `CHK("rx_first", exp_q[0].first, rx_first)
          void'(exp_q.pop_front());
        end
      end
      if (tx_ready === 1'b1) begin
        void'(tx_q.pop_front());
        tx_data <= #1 (tx_q.size() > 0) ? tx_q[0] : 8'h00;
        tx_valid <= #1 (tx_q.size() > 0);
      end
      if (sda_oe === 1'b1) `CHK("sda_o", 1'b0, sda_o)
    end
    if (cyc == LIMIT) begin
      fails++;
      summarize();
    end
  end
  always @(posedge sda_oe) begin
    n_oe++;
    `CHK("oe_rise_scl", 1'b0, scl)
  end
  task automatic cyc_wait(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // expected buffer entry: the first flag marks the byte right after a start
  function automatic etw_pkg::etw_rx_s exp_rx(input logic f, input logic [7:0] d);
    etw_pkg::etw_rx_s e;
    e.first = f;
    e.data = d;
    return e;
  endfunction
  task automatic st();
    first = 1'b1;
    m.start();
  endtask
  // nk is the level the master expects to see in the ninth clock
  task automatic wr(input int n, input logic nk);
    logic [7:0] d;
    logic a;
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      // queued ahead: the byte can leave the buffer before the ack clock ends
      if (!nk) exp_q.push_back(exp_rx(first, d));
      m.put_byte(d, 8, a);
      `CHK("ack", nk, a)
      first = 1'b0;
    end
  endtask
  initial begin
    logic [7:0] rd;
    logic [7:0] txe[3];
    logic a;
    int k;
    fork
      begin
        #1;
        m.reset_clocks(8);
      end
      cyc_wait(12);
    join
    `CHK("rst_standby", 1'b1, standby)
    `CHK("rst_oe", 1'b0, sda_oe)
    `CHK("rst_idle", 1'b1, idle)
    `CHK("rst_rxv", 1'b0, rx_valid)
    rstn = 1'b1;
    cyc_wait(4);
    st();
    cyc_wait(8);
    `CHK("early", 1, n_early)
    `CHK("wake", 1'b0, standby)
    `CHK("busy", 1'b0, idle)
    rx_en = 1'b1;
    wr(1, 1'b0);
    m.put_byte(8'($random(seed)), 3, a);
    st();
    wr(2, 1'b0);
    m.stop();
    cyc_wait(8);
    `CHK("stop_standby", 1'b1, standby)
    `CHK("stop_idle", 1'b1, idle)
    `CHK("starts_a", 2, n_start)
    `CHK("stops_a", 1, n_stop)
    k = n_oe;
    m.wait_power_up();
    m.dummy_clocks(9, 1'b0);
    cyc_wait(8);
    `CHK("quiet_oe", k, n_oe)
    `CHK("quiet_start", 2, n_start)
    st();
    wr(1, 1'b0);
    cyc_wait(1);
    ack_en = 1'b0;
    wr(1, 1'b1);
    cyc_wait(1);
    ack_en = 1'b1;
    wr(1, 1'b1);
    st();
    wr(2, 1'b0);
    m.stop();
    `CHK("ovr_none", 0, n_ovr)
    st();
    wr(16, 1'b0);
    m.stop();
    cyc_wait(40);
    rx_en = 1'b0;
    st();
    wr(8, 1'b0);
    wr(1, 1'b1);
    cyc_wait(8);
    `CHK("overrun", 1, n_ovr)
    m.stop();
    cyc_wait(1);
    rx_en = 1'b1;
    k = 0;
    while (exp_q.size() > 0 && k < 200) begin
      cyc_wait(1);
      k++;
    end
    cyc_wait(2);
    `CHK("drained", 1'b0, rx_valid)
    for (int i = 0; i < 3; i++) begin
      txe[i] = 8'($random(seed));
      tx_q.push_back(txe[i]);
    end
    tx_data = txe[0];
    tx_valid = 1'b1;
    tx_mode = 1'b1;
    st();
    wr(1, 1'b0);
    for (int i = 0; i < 3; i++) begin
      m.get_byte(i == 2, rd);
      `CHK("rd", txe[i], rd)
    end
    cyc_wait(8);
    `CHK("nack", 1, n_nack)
    `CHK("rd_release", 1'b0, sda_oe)
    `CHK("tx_used", 0, tx_q.size())
    tx_mode = 1'b0;
    m.stop();
    cyc_wait(8);
    `CHK("starts", 7, n_start)
    `CHK("stops", 5, n_stop)
    `CHK("end_standby", 1'b1, standby)
    `CHK("early_end", 1, n_early)
    summarize();
  end
endmodule // etw_frontend_tb_top

//--- verification/etw_master_model.sv
`timescale 1ns/1ps
// bus master: drives scl, pulls sda low or releases it
module etw_master_model #(
  parameter int PH_NS = 330,
  parameter int WAIT_NS = 800
) (
  output logic scl_o,
  output logic sda_low_o,
  input wire logic sda_i
);
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic wait_power_up();
    #(WAIT_NS);
  endtask
  // fast clocks with sda released, only while the device is held in reset
  task automatic reset_clocks(input int n);
    repeat (n) begin
      scl_o = 1'b0;
      #15;
      scl_o = 1'b1;
      #15;
    end
  endtask
  task automatic start();
    if (!scl_o) begin
      #(PH_NS / 4);
      sda_low_o = 1'b0;
      #(PH_NS);
      scl_o = 1'b1;
      #(PH_NS);
    end
    sda_low_o = 1'b1;
    #(PH_NS);
    scl_o = 1'b0;
  endtask
  task automatic stop();
    #(PH_NS / 4);
    sda_low_o = 1'b1;
    #(PH_NS);
    scl_o = 1'b1;
    #(PH_NS);
    sda_low_o = 1'b0;
    #(PH_NS);
  endtask
  // sda moves a quarter phase after scl falls, never together with it
  task automatic bit_cycle(input logic b, output logic got);
    #(PH_NS / 4);
    sda_low_o = !b;
    #(PH_NS);
    scl_o = 1'b1;
    #(PH_NS);
    got = sda_i;
    scl_o = 1'b0;
  endtask
  task automatic dummy_clocks(input int n, input logic b);
    logic g;
    scl_o = 1'b0;
    repeat (n) bit_cycle(b, g);
    #(PH_NS / 4);
    sda_low_o = 1'b0;
    #(PH_NS);
    scl_o = 1'b1;
    #(PH_NS);
  endtask
  task automatic put_byte(input logic [7:0] d, input int nbits, output logic ack);
    logic g;
    ack = 1'b1;
    for (int i = 7; i > 7 - nbits; i--) bit_cycle(d[i], g);
    if (nbits == 8) bit_cycle(1'b1, ack);
  endtask
  task automatic get_byte(input logic nack, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
    bit_cycle(nack, g);
  endtask
endmodule // etw_master_model

//--- verilog/etw_fifo.sv
`timescale 1ns/1ps
module etw_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } etw_fifo_s;

  etw_fifo_s fifo_r;
  etw_fifo_s fifo_nxt;
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic wr;
  logic rd;

  assign in_ready_o = fifo_r.cnt != FULL_CNT;
  assign out_valid_o = fifo_r.cnt != '0;
  assign out_data_o = mem_r[fifo_r.rp];
  assign wr = in_valid_i && in_ready_o;
  assign rd = out_valid_o && out_ready_i;

  always_comb begin
    fifo_nxt = fifo_r;
    if (wr) begin
      fifo_nxt.wp = (fifo_r.wp == LAST_PTR) ? '0 : fifo_r.wp + 1'b1;
    end
    if (rd) begin
      fifo_nxt.rp = (fifo_r.rp == LAST_PTR) ? '0 : fifo_r.rp + 1'b1;
    end
    if (wr && !rd) begin
      fifo_nxt.cnt = fifo_r.cnt + 1'b1;
    end else if (rd && !wr) begin
      fifo_nxt.cnt = fifo_r.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      fifo_r <= '0;
    end else begin
      fifo_r <= fifo_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (wr) begin
      mem_r[fifo_r.wp] <= in_data_i;
    end
  end

  a_fifo_bound: assert property (@(posedge clk_i) disable iff (!rstn_i)
    (fifo_r.cnt == FULL_CNT) |-> !in_ready_o ##1 (fifo_r.cnt <= FULL_CNT))
    else $error("fifo count passed its depth");

endmodule // etw_fifo

//--- verilog/etw_frontend.sv
`timescale 1ns/1ps
// Behaviour
// [R1] held in reset, then standby, bus ignored
// [R2] master waits 100 us before first command
// [R3] sample on scl rise, drive on fall
// [R4] bytes shift most significant bit first
// [R5] eight data clocks plus one acknowledge clock
// [R6] master never pauses inside a byte
// [R7] data changes only while clock low
// [R8] sda fall under high scl is start
// [R9] silent on bus until a start
// [R10] sda rise under high scl is stop
// [R11] stop returns device to standby
// [R12] repeated start begins a new command
// [R13] no limit on bytes per transfer
// [R14] idle only when both lines high
// [R15] sda open drain, scl input only
// [R16] release after eighth bit, ack low ninth
// [R17] master nack on read releases sda
// [R18] start or stop abandons partial byte
module etw_frontend #(
  parameter int FIFO_DEPTH = etw_pkg::RX_FIFO_DEPTH,
  parameter int WAKE_CYC = etw_pkg::POWER_UP_COMMAND_WAIT_CYC
) (
  input wire logic CLOCK_I,
  input wire logic RSTN_I,
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE_O,
  output logic [etw_pkg::BYTE_W-1:0] RX_DATA_O,
  output logic RX_FIRST_O,
  output logic RX_VALID_O,
  input wire logic RX_READY_I,
  input wire logic [etw_pkg::BYTE_W-1:0] TX_DATA_I,
  input wire logic TX_VALID_I,
  output logic TX_READY_O,
  input wire logic TX_MODE_I,
  input wire logic ACK_I,
  output logic STANDBY_O,
  output logic BUS_IDLE_O,
  output logic START_O,
  output logic STOP_O,
  output logic NACK_O,
  output logic OVERRUN_O,
  output logic EARLY_CMD_O
);

  localparam logic [etw_pkg::WAKE_W-1:0] WAKE_END = etw_pkg::WAKE_W'(WAKE_CYC);

  typedef struct packed {
    logic [etw_pkg::SYNC_STAGES-1:0] scl_s;
    logic [etw_pkg::SYNC_STAGES-1:0] sda_s;
    logic [etw_pkg::SYNC_STAGES-1:0] tgl_s;
    logic tgl_seen;
    logic scl_f;
    logic sda_f;
    logic idle;
    etw_pkg::etw_state_e st;
    logic [etw_pkg::CNT_W-1:0] cnt;
    logic [etw_pkg::BYTE_W-1:0] sh;
    logic [etw_pkg::BYTE_W-1:0] tx;
    logic first;
    logic drv;
    logic standby;
    logic [etw_pkg::WAKE_W-1:0] wake;
    logic start_p;
    logic stop_p;
    logic nack_p;
    logic ovr_p;
    logic early_p;
  } etw_sys_s;

  typedef struct packed {
    logic rstn_m;
    logic rstn_q;
    logic smp;
    logic tgl;
  } etw_lnk_s;

  etw_sys_s sys_r;
  etw_sys_s sys_nxt;
  etw_lnk_s lnk_r;
  etw_lnk_s lnk_nxt;
  logic drv_link_r;

  logic bit_ev;
  logic start_c;
  logic stop_c;
  logic push;
  logic go_next;
  logic tx_take;
  logic fifo_in_ready;
  etw_pkg::etw_rx_s rx_in;
  etw_pkg::etw_rx_s rx_out;

  // link side: runs on the bus clock itself
  always_comb begin
    lnk_nxt = lnk_r;
    lnk_nxt.rstn_m = RSTN_I;
    lnk_nxt.rstn_q = lnk_r.rstn_m;
    // raw reset counts only while the synced copy is low: a release that waited
    // for two bus clocks would swallow the first bits; a metastable release edge is harmless in standby
    if (!lnk_r.rstn_q && !RSTN_I) begin
      lnk_nxt.smp = 1'b1;
      lnk_nxt.tgl = 1'b0;
    end else begin
      // every clock carries a bit; the toggle marks it for the core
      lnk_nxt.smp = SDA_I; // [R3]
      lnk_nxt.tgl = !lnk_r.tgl; // [R6]
    end
  end

  always_ff @(posedge SCL_I) begin
    lnk_r <= lnk_nxt;
  end

  // drv is only changed a few core cycles after a rise, so it is
  // settled long before the next fall samples it
  always_ff @(negedge SCL_I) begin
    if (!lnk_r.rstn_q) begin
      drv_link_r <= 1'b0;
    end else begin
      drv_link_r <= sys_r.drv; // [R3] [R7]
    end
  end

  // core side
  always_comb begin
    sys_nxt = sys_r;
    push = 1'b0;
    go_next = 1'b0;
    tx_take = 1'b0;
    sys_nxt.start_p = 1'b0;
    sys_nxt.stop_p = 1'b0;
    sys_nxt.nack_p = 1'b0;
    sys_nxt.ovr_p = 1'b0;
    sys_nxt.early_p = 1'b0;
    rx_in.first = sys_r.first;
    rx_in.data = {sys_r.sh[etw_pkg::BYTE_W-2:0], lnk_r.smp};

    sys_nxt.scl_s = {sys_r.scl_s[etw_pkg::SYNC_STAGES-2:0], SCL_I};
    sys_nxt.sda_s = {sys_r.sda_s[etw_pkg::SYNC_STAGES-2:0], SDA_I};
    sys_nxt.tgl_s = {sys_r.tgl_s[etw_pkg::SYNC_STAGES-2:0], lnk_r.tgl};
    if (sys_r.scl_s[2] == sys_r.scl_s[1]) begin
      sys_nxt.scl_f = sys_r.scl_s[2];
    end
    if (sys_r.sda_s[2] == sys_r.sda_s[1]) begin
      sys_nxt.sda_f = sys_r.sda_s[2];
    end

    bit_ev = (sys_r.tgl_s[2] == sys_r.tgl_s[1]) && (sys_r.tgl_s[2] != sys_r.tgl_seen);
    if (bit_ev) begin
      sys_nxt.tgl_seen = sys_r.tgl_s[2];
    end

    // conditions need scl high both before and after the sda move
    start_c = sys_r.scl_f && sys_nxt.scl_f && sys_r.sda_f && !sys_nxt.sda_f; // [R8]
    stop_c = sys_r.scl_f && sys_nxt.scl_f && !sys_r.sda_f && sys_nxt.sda_f; // [R10]
    sys_nxt.idle = sys_nxt.scl_f && sys_nxt.sda_f; // [R14]

    if (sys_r.wake != WAKE_END) begin
      sys_nxt.wake = sys_r.wake + 1'b1;
    end

    if (start_c) begin
      // a repeated start lands here too, from any state
      sys_nxt.st = etw_pkg::ST_RECV; // [R8] [R12]
      sys_nxt.cnt = etw_pkg::CNT_ZERO; // [R18]
      sys_nxt.drv = 1'b0;
      sys_nxt.standby = 1'b0;
      sys_nxt.first = 1'b1;
      sys_nxt.start_p = 1'b1;
      // flags a master that ignored the power-up wait
      sys_nxt.early_p = sys_r.wake != WAKE_END; // [R2]
    end else if (stop_c) begin
      sys_nxt.st = etw_pkg::ST_STANDBY; // [R11]
      sys_nxt.cnt = etw_pkg::CNT_ZERO; // [R18]
      sys_nxt.drv = 1'b0;
      sys_nxt.standby = 1'b1;
      sys_nxt.stop_p = 1'b1;
    end else if (bit_ev) begin
      case (sys_r.st)
        etw_pkg::ST_RECV: begin
          sys_nxt.sh = rx_in.data; // [R4]
          // wraps freely: byte count per transfer is unbounded
          sys_nxt.cnt = sys_r.cnt + etw_pkg::CNT_STEP; // [R13]
          if (sys_r.cnt == etw_pkg::LAST_DATA_BIT) begin
            // a full buffer answers not-acknowledge, pushing back
            push = ACK_I && fifo_in_ready; // [R5]
            sys_nxt.ovr_p = ACK_I && !fifo_in_ready;
            sys_nxt.drv = push; // [R16]
            sys_nxt.st = etw_pkg::ST_ACK_OUT;
          end
        end
        etw_pkg::ST_ACK_OUT: begin
          if (sys_r.drv) begin
            go_next = 1'b1;
          end else begin
            sys_nxt.st = etw_pkg::ST_HALT;
          end
        end
        etw_pkg::ST_SEND: begin
          sys_nxt.cnt = sys_r.cnt + etw_pkg::CNT_STEP;
          if (sys_r.cnt == etw_pkg::LAST_DATA_BIT) begin
            sys_nxt.drv = 1'b0; // [R16]
            sys_nxt.st = etw_pkg::ST_ACK_IN;
          end else begin
            sys_nxt.drv = !sys_r.tx[etw_pkg::BYTE_W-1]; // [R4]
            sys_nxt.tx = {sys_r.tx[etw_pkg::BYTE_W-2:0], 1'b0};
          end
        end
        etw_pkg::ST_ACK_IN: begin
          if (!lnk_r.smp) begin
            go_next = 1'b1;
          end else begin
            sys_nxt.nack_p = 1'b1; // [R17]
            sys_nxt.st = etw_pkg::ST_HALT;
          end
        end
        default: begin
          // standby and halt ignore clocks until a start
          sys_nxt.drv = 1'b0; // [R9]
        end
      endcase

      if (go_next) begin
        sys_nxt.drv = 1'b0;
        if (!TX_MODE_I) begin
          sys_nxt.st = etw_pkg::ST_RECV;
        end else if (TX_VALID_I) begin
          tx_take = 1'b1;
          sys_nxt.drv = !TX_DATA_I[etw_pkg::BYTE_W-1]; // [R4]
          sys_nxt.tx = {TX_DATA_I[etw_pkg::BYTE_W-2:0], 1'b0};
          sys_nxt.st = etw_pkg::ST_SEND;
        end else begin
          // nothing to send: stay off the line
          sys_nxt.st = etw_pkg::ST_HALT;
        end
      end
    end

    if (push) begin
      sys_nxt.first = 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RSTN_I) begin
      sys_r.scl_s <= etw_pkg::PIN_SYNC_RST; // [R1]
      sys_r.sda_s <= etw_pkg::PIN_SYNC_RST;
      sys_r.tgl_s <= etw_pkg::TGL_SYNC_RST;
      sys_r.tgl_seen <= 1'b0;
      sys_r.scl_f <= 1'b1;
      sys_r.sda_f <= 1'b1;
      sys_r.idle <= 1'b1;
      sys_r.st <= etw_pkg::ST_STANDBY;
      sys_r.cnt <= etw_pkg::CNT_ZERO;
      sys_r.sh <= etw_pkg::BYTE_RST;
      sys_r.tx <= etw_pkg::BYTE_RST;
      sys_r.first <= 1'b0;
      sys_r.drv <= 1'b0;
      sys_r.standby <= 1'b1;
      sys_r.wake <= etw_pkg::WAKE_RST;
      sys_r.start_p <= 1'b0;
      sys_r.stop_p <= 1'b0;
      sys_r.nack_p <= 1'b0;
      sys_r.ovr_p <= 1'b0;
      sys_r.early_p <= 1'b0;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  etw_fifo #(
    .WIDTH($bits(etw_pkg::etw_rx_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_i(CLOCK_I),
    .rstn_i(RSTN_I),
    .in_valid_i(push),
    .in_ready_o(fifo_in_ready),
    .in_data_i(rx_in),
    .out_valid_o(RX_VALID_O),
    .out_ready_i(RX_READY_I),
    .out_data_o(rx_out)
  );

  // pull low or let go; the pull-up makes the high level
  assign SDA_O = 1'b0; // [R15]
  assign SDA_OE_O = drv_link_r && !sys_r.standby; // [R9] [R15]
  assign RX_DATA_O = rx_out.data;
  assign RX_FIRST_O = rx_out.first;
  assign TX_READY_O = tx_take;
  assign STANDBY_O = sys_r.standby;
  assign BUS_IDLE_O = sys_r.idle;
  assign START_O = sys_r.start_p;
  assign STOP_O = sys_r.stop_p;
  assign NACK_O = sys_r.nack_p;
  assign OVERRUN_O = sys_r.ovr_p;
  assign EARLY_CMD_O = sys_r.early_p;

  a_reset_standby: assert property (@(posedge CLOCK_I) // [R1]
    $rose(RSTN_I) |-> sys_r.standby && !sys_r.drv && sys_r.st == etw_pkg::ST_STANDBY)
    else $error("not in standby after reset release");

  a_start_cond: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // [R8]
    sys_r.start_p |-> sys_r.scl_f && !sys_r.sda_f && $past(sys_r.sda_f)
      && $past(sys_r.scl_f))
    else $error("start flagged without sda fall under high scl");

  a_start_wake: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // [R18]
    sys_r.start_p |-> !sys_r.standby && sys_r.cnt == etw_pkg::CNT_ZERO
      && sys_r.st == etw_pkg::ST_RECV && sys_r.first)
    else $error("start did not open a fresh command");

  a_stop_cond: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // [R10]
    sys_r.stop_p |-> sys_r.scl_f && sys_r.sda_f && !$past(sys_r.sda_f))
    else $error("stop flagged without sda rise under high scl");

  a_stop_standby: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // [R11]
    sys_r.stop_p |-> sys_r.standby && !sys_r.drv && sys_r.st == etw_pkg::ST_STANDBY)
    else $error("stop did not return to standby");

  a_silent_idle: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // [R9]
    (sys_r.st == etw_pkg::ST_STANDBY || sys_r.st == etw_pkg::ST_HALT)
      && !$past(bit_ev) |-> !sys_r.drv)
    else $error("data line pulled while idle or halted");

  a_byte_push: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // [R5]
    push |-> sys_r.st == etw_pkg::ST_RECV && sys_r.cnt == etw_pkg::LAST_DATA_BIT
      ##1 sys_r.st == etw_pkg::ST_ACK_OUT && sys_r.drv)
    else $error("byte taken off the eighth bit");

  a_release_eighth: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // [R16]
    bit_ev && !start_c && !stop_c && sys_r.st == etw_pkg::ST_SEND
      && sys_r.cnt == etw_pkg::LAST_DATA_BIT |=> !sys_r.drv
      && sys_r.st == etw_pkg::ST_ACK_IN)
    else $error("line not released after eighth sent bit");

  a_nack_release: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // [R17]
    sys_r.nack_p |-> !sys_r.drv && sys_r.st == etw_pkg::ST_HALT)
    else $error("master nack did not release the line");

  a_tx_msb: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // [R4]
    tx_take |=> sys_r.drv == !$past(TX_DATA_I[etw_pkg::BYTE_W-1])
      && sys_r.st == etw_pkg::ST_SEND)
    else $error("first sent bit is not the top bit");

  a_idle_level: assert property (@(posedge CLOCK_I) disable iff (!RSTN_I) // [R14]
    (!sys_r.scl_f || !sys_r.sda_f) |-> !BUS_IDLE_O)
    else $error("bus idle shown while clock low");

endmodule // etw_frontend

//--- verilog/etw_pkg.sv
package etw_pkg;

  // system clock
  localparam int CLK_PERIOD_NS = 40;

  // the bus master waits this long after supply is stable
  localparam int POWER_UP_COMMAND_WAIT_US = 100;
  localparam int POWER_UP_COMMAND_WAIT_CYC =
    (POWER_UP_COMMAND_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_W = 12;

  // byte framing
  localparam int BYTE_W = 8;
  localparam int CNT_W = 3;
  localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
  localparam logic [CNT_W-1:0] CNT_STEP = 3'h1;
  localparam logic [CNT_W-1:0] LAST_DATA_BIT = 3'h7;

  // synchronisers and register reset values
  localparam int SYNC_STAGES = 3;
  localparam logic [SYNC_STAGES-1:0] PIN_SYNC_RST = 3'h7;
  localparam logic [SYNC_STAGES-1:0] TGL_SYNC_RST = 3'h0;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
  localparam logic [WAKE_W-1:0] WAKE_RST = 12'h000;

  localparam int RX_FIFO_DEPTH = 8;

  typedef enum logic [2:0] {
    ST_STANDBY,
    ST_RECV,
    ST_ACK_OUT,
    ST_SEND,
    ST_ACK_IN,
    ST_HALT
  } etw_state_e;

  typedef struct packed {
    logic first;
    logic [BYTE_W-1:0] data;
  } etw_rx_s;

endpackage
